// File: hdl/pifp_pkg.sv
package pifp_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets on the APB bus
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_FLAGS2  = 8'h00;
	localparam logic [7:0] OFS_EN1     = 8'h04;
	localparam logic [7:0] OFS_EN2     = 8'h08;
	localparam logic [7:0] OFS_PRIO1   = 8'h0C;
	localparam logic [7:0] OFS_PRIO2   = 8'h10;
	localparam logic [7:0] OFS_RCAUSE  = 8'h14;
	localparam logic [7:0] OFS_CORECTL = 8'h18;
	localparam logic [7:0] OFS_FLAGS1  = 8'h1C;

	// ------------------------------------------------------------------
	// Field positions and masks
	// ------------------------------------------------------------------
	localparam int BIT_UNIMPL      = 5;
	localparam int BIT_PARPORT     = 7;
	localparam int BIT_PRIO_ON     = 7;
	localparam int BIT_SOFT_BOR    = 6;
	localparam int BIT_RESET_INSTR = 4;
	localparam int BIT_WDT_TIMEOUT = 3;
	localparam int BIT_POWER_DOWN  = 2;
	localparam int BIT_POWER_ON    = 1;
	localparam int BIT_BROWNOUT    = 0;
	localparam int BIT_GLOBAL_HIGH = 1;
	localparam int BIT_GLOBAL_LOW  = 0;

	// Implemented bits of the second-group registers (bit 5 absent)
	localparam logic [7:0] MASK_GROUP2  = 8'hDF;
	// Implemented bits of the first group on the large package
	localparam logic [7:0] MASK_GROUP1  = 8'hFF;
	// First group on the small package: parallel port bit absent
	localparam logic [7:0] MASK_GROUP1S = 8'h7F;
	// Writable reset-cause bits: timeout and power-down are read-only
	localparam logic [7:0] MASK_RCAUSE_W = 8'hD3;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_FLAGS  = 8'h00;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_PRIO   = 8'hFF;
	localparam logic [1:0] RST_CORE   = 2'h0;
	localparam logic [7:0] RST_RCAUSE = 8'h1C;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	// Reset-cause register helper states
	typedef enum logic [1:0] {
		PIFP_RC_IDLE  = 2'b00,
		PIFP_RC_LATCH = 2'b01,
		PIFP_RC_RUN   = 2'b10
	} pifp_rc_state_e;

endpackage

// File: hdl/pifp_flag_bit.sv
`timescale 1ns/1ps
// Sticky event flag: hardware set wins over a software clear
module pifp_flag_bit (
	input  wire logic sys_clk,   // System clock
	input  wire logic reset,     // Synchronous reset, high
	input  wire logic event_in,  // One-cycle event from a source
	input  wire logic wr_en,     // Software write to this bit
	input  wire logic wr_val,    // Value software writes
	output logic      flag       // Sticky flag
);
	// Set has priority so an event in the clear cycle is kept
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flag <= 1'b0;
		end else if (event_in) begin
			flag <= 1'b1;
		end else if (wr_en) begin
			flag <= wr_val;
		end
	end

	a_set_wins_clear : assert property (@(posedge sys_clk) disable iff (reset)
		event_in |=> flag)
		else $error("flag lost an event");
endmodule

// File: hdl/pifp_reset_cause.sv
`timescale 1ns/1ps
// Reset-cause register with priority-enable bit
module pifp_reset_cause import pifp_pkg::*; (
	input  wire logic       sys_clk,       // System clock
	input  wire logic       reset,         // Synchronous reset, high
	input  wire logic       cfg_soft_bor,  // Configured brownout enable
	input  wire logic       por_event,     // Reset came from power-on
	input  wire logic       bor_event,     // Reset came from brown-out
	input  wire logic       rst_instr,     // Reset instruction seen
	input  wire logic       wdt_timeout,   // Watchdog timed out
	input  wire logic       sleep_entry,   // Sleep instruction executed
	input  wire logic       wr_en,         // Software write strobe
	input  wire logic [7:0] wr_data,       // Software write data
	output logic      [7:0] value          // Register contents
);
	pifp_rc_state_e state;

	// Configuration-dependent bits are caught after reset release
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state <= PIFP_RC_LATCH;
		end else begin
			case (state)
				PIFP_RC_LATCH: state <= PIFP_RC_RUN;
				PIFP_RC_RUN:   state <= PIFP_RC_RUN;
				default:       state <= PIFP_RC_LATCH;
			endcase
		end
	end

	// Status flags: software may set or clear the writable ones
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			value <= RST_RCAUSE;
		end else if (state == PIFP_RC_LATCH) begin
			value[BIT_SOFT_BOR] <= cfg_soft_bor;               // [RQ18]
			value[BIT_POWER_ON] <= ~por_event;                 // [RQ18]
			value[BIT_BROWNOUT] <= ~bor_event;
		end else begin
			if (wr_en) begin
				value <= (value & ~MASK_RCAUSE_W)
					| (wr_data & MASK_RCAUSE_W);                  // [RQ16]
			end
			if (rst_instr) begin
				value[BIT_RESET_INSTR] <= 1'b0;                 // [RQ17]
			end
			if (wdt_timeout) begin
				value[BIT_WDT_TIMEOUT] <= 1'b0;                 // [RQ17]
			end
			if (sleep_entry) begin
				value[BIT_POWER_DOWN] <= 1'b0;                  // [RQ17]
			end
			value[BIT_UNIMPL] <= 1'b0;
		end
	end

	a_prio_reset_low : assert property (@(posedge sys_clk)
		$fell(reset) |-> !value[BIT_PRIO_ON]) // [RQ16]
		else $error("priority enable not zero after reset");
	a_timeout_ro : assert property (@(posedge sys_clk) disable iff (reset)
		(state == PIFP_RC_RUN && !wdt_timeout && wr_en)
		|=> value[BIT_WDT_TIMEOUT] == $past(value[BIT_WDT_TIMEOUT])) // [RQ17]
		else $error("timeout flag changed by a write");
endmodule

// File: hdl/pifp_irq_unit.sv
// Overview of operation
// [RQ1] Bit 7 flag sets on oscillator failure; software clears.
// [RQ2] Bit 6 flag sets on comparator change; software clears.
// [RQ3] Bit 5 of second flag, enable, priority registers reads zero.
// [RQ4] Bit 4 flag sets when a memory write completes; software clears.
// [RQ5] Bit 3 flag sets on bus collision; software clears.
// [RQ6] Bit 2 flag sets on voltage detect per selected direction.
// [RQ7] Bit 1 flag sets on timer 3 overflow; software clears.
// [RQ8] Bit 0 flag sets on capture or compare match, not in PWM.
// [RQ9] Second flag register bits are read/write and reset to zero.
// [RQ10] Without priority, peripheral global enable also gates requests.
// [RQ11] First enable register holds eight source enables, reset zero.
// [RQ12] Second enable register mirrors flags; 1 enables; reset zero.
// [RQ13] Small package: parallel port bit 7 of first registers reads zero.
// [RQ14] Priority bits steer sources only when priority mode is on.
// [RQ15] Priority bit 1 is high, 0 low; implemented bits reset to one.
// [RQ16] Reset-cause bit 7 enables two levels; read/write; resets zero.
// [RQ17] Reset-cause flags provided; timeout and power-down read-only.
// [RQ18] Soft brownout and power-on bits reset from configuration.
// [RQ19] Flags set on events regardless of any enable.
// [RQ20] With priority on, high global gates high, low gates low.
// [RQ21] Two request outputs, high and low, gated by global enables.
`timescale 1ns/1ps
module pifp_irq_unit import pifp_pkg::*; #(
	parameter bit SMALL_PACKAGE = 1'b0  // 1 = parallel port absent
) (
	input  wire logic        sys_clk,         // System clock, 20 MHz
	input  wire logic        reset,           // Synchronous reset, high
	// APB slave
	input  wire logic        psel,            // Slave select
	input  wire logic        penable,         // Access phase
	input  wire logic        pwrite,          // Write direction
	input  wire logic [7:0]  paddr,           // Byte address
	input  wire logic [31:0] pwdata,          // Write data
	output logic      [31:0] prdata,          // Read data
	output logic             pready,          // Transfer done
	output logic             pslverr,         // Unmapped address
	// Peripheral events, one-cycle pulses on sys_clk; detector inputs are levels
	input  wire logic        osc_fail_evt,    // Switched to internal osc
	input  wire logic        cmp_change_evt,  // Comparator input changed
	input  wire logic        nv_write_done,   // Memory write completed
	input  wire logic        bus_coll_evt,    // Serial bus collision
	input  wire logic        volt_above,      // Detector: above trip
	input  wire logic        volt_below,      // Detector: below trip
	input  wire logic        voltage_direction_sel, // 1 = rising trip
	input  wire logic        timer3_ovf_evt,  // Timer 3 overflowed
	input  wire logic        cc2_event,       // Capture/compare event
	input  wire logic [1:0]  cc2_mode,        // 0 off,1 capt,2 cmp,3 pwm
	input  wire logic [7:0]  flags1_evt,      // First-group source events
	// Reset-cause sources
	input  wire logic        cfg_soft_bor,    // Configured brownout en
	input  wire logic        por_event,       // Power-on reset occurred
	input  wire logic        bor_event,       // Brown-out reset occurred
	input  wire logic        rst_instr,       // Reset instruction
	input  wire logic        wdt_timeout,     // Watchdog timeout
	input  wire logic        sleep_entry,     // Sleep executed
	// Requests to the core
	output logic             irq_high,        // High-level request
	output logic             irq_low          // Low-level request
);

	// ------------------------------------------------------------------
	// Local constants
	// ------------------------------------------------------------------
	localparam logic [1:0] CC_CAPTURE = 2'h1;
	localparam logic [1:0] CC_COMPARE = 2'h2;
	localparam logic [7:0] MASK_G1 = SMALL_PACKAGE ? MASK_GROUP1S
		: MASK_GROUP1;

	// ------------------------------------------------------------------
	// Registers and decode
	// ------------------------------------------------------------------
	logic [7:0] flags2;
	logic [7:0] flags1;
	logic [7:0] en1;
	logic [7:0] en2;
	logic [7:0] prio1;
	logic [7:0] prio2;
	logic [7:0] rcause;
	logic [1:0] corectl;
	logic [7:0] evt2;
	logic       wr_acc;
	logic       wr_flags2;
	logic       wr_flags1;
	logic       mapped;
	logic       priority_levels_on;
	logic       high_level_global_en;
	logic       low_level_global_en;
	logic       volt_prev;
	logic       volt_now;
	logic [1:0] volt_sync1;
	logic [1:0] volt_sync2;
	logic [31:0] next_rdata;
	logic       next_high;
	logic       next_low;
	logic [7:0] pend1;
	logic [7:0] pend2;

	// Write takes effect only in the access phase
	assign wr_acc    = psel && penable && pwrite;
	assign wr_flags2 = wr_acc && (paddr == OFS_FLAGS2);
	assign wr_flags1 = wr_acc && (paddr == OFS_FLAGS1);

	assign priority_levels_on   = rcause[BIT_PRIO_ON];
	assign high_level_global_en = corectl[BIT_GLOBAL_HIGH];
	assign low_level_global_en  = corectl[BIT_GLOBAL_LOW];

	// ------------------------------------------------------------------
	// Event conditioning for the second flag group
	// ------------------------------------------------------------------
	// Detector levels come from an analog comparator with no relation to
	// sys_clk; two flops keep metastability away from the edge detector
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			volt_sync1 <= 2'h0;
			volt_sync2 <= 2'h0;
		end else begin
			volt_sync1 <= {volt_above, volt_below};
			volt_sync2 <= volt_sync1;
		end
	end

	// Voltage trip: only the crossing into the selected condition counts
	assign volt_now = voltage_direction_sel ? volt_sync2[1]
		: volt_sync2[0];

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			volt_prev <= 1'b0;
		end else begin
			volt_prev <= volt_now;
		end
	end

	// Map each source to its flag position; bit 5 has no source
	always_comb begin
		evt2      = 8'h00;
		evt2[7]   = osc_fail_evt;                               // [RQ1]
		evt2[6]   = cmp_change_evt;                             // [RQ2]
		evt2[4]   = nv_write_done;                              // [RQ4]
		evt2[3]   = bus_coll_evt;                               // [RQ5]
		evt2[2]   = volt_now && !volt_prev;                     // [RQ6]
		evt2[1]   = timer3_ovf_evt;                             // [RQ7]
		evt2[0]   = cc2_event && ((cc2_mode == CC_CAPTURE)
			|| (cc2_mode == CC_COMPARE));                         // [RQ8]
	end

	// ------------------------------------------------------------------
	// Flag bits: set independent of enables, set wins over clear
	// ------------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flags
			if (MASK_GROUP2[gi]) begin : g_f2
				pifp_flag_bit u_f2 (
					.sys_clk  (sys_clk),
					.reset    (reset),
					.event_in (evt2[gi]),                         // [RQ19]
					.wr_en    (wr_flags2),                        // [RQ9]
					.wr_val   (pwdata[gi]),
					.flag     (flags2[gi])
				);
			end else begin : g_f2u
				assign flags2[gi] = 1'b0;                       // [RQ3]
			end
			if (MASK_G1[gi]) begin : g_f1
				pifp_flag_bit u_f1 (
					.sys_clk  (sys_clk),
					.reset    (reset),
					.event_in (flags1_evt[gi]),
					.wr_en    (wr_flags1),
					.wr_val   (pwdata[gi]),
					.flag     (flags1[gi])
				);
			end else begin : g_f1u
				assign flags1[gi] = 1'b0;                       // [RQ13]
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// Enable, priority and core control registers
	// ------------------------------------------------------------------
	// Unimplemented bits are masked on write so they stay zero
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			en1 <= RST_ENABLE;                                  // [RQ11]
			en2 <= RST_ENABLE;                                  // [RQ12]
		end else if (wr_acc) begin
			if (paddr == OFS_EN1) begin
				en1 <= pwdata[7:0] & MASK_G1;                     // [RQ13]
			end
			if (paddr == OFS_EN2) begin
				en2 <= pwdata[7:0] & MASK_GROUP2;                 // [RQ3]
			end
		end
	end

	// Priority bits reset to high on every implemented position
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			prio1 <= RST_PRIO & MASK_G1;                        // [RQ15]
			prio2 <= RST_PRIO & MASK_GROUP2;                    // [RQ15]
		end else if (wr_acc) begin
			if (paddr == OFS_PRIO1) begin
				prio1 <= pwdata[7:0] & MASK_G1;
			end
			if (paddr == OFS_PRIO2) begin
				prio2 <= pwdata[7:0] & MASK_GROUP2;
			end
		end
	end

	// Global enables normally live in the core; mirrored here for gating
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			corectl <= RST_CORE;
		end else if (wr_acc && (paddr == OFS_CORECTL)) begin
			corectl <= pwdata[1:0];
		end
	end

	pifp_reset_cause u_rcause (
		.sys_clk      (sys_clk),
		.reset        (reset),
		.cfg_soft_bor (cfg_soft_bor),
		.por_event    (por_event),
		.bor_event    (bor_event),
		.rst_instr    (rst_instr),
		.wdt_timeout  (wdt_timeout),
		.sleep_entry  (sleep_entry),
		.wr_en        (wr_acc && (paddr == OFS_RCAUSE)),
		.wr_data      (pwdata[7:0]),
		.value        (rcause)
	);

	// ------------------------------------------------------------------
	// Request routing
	// ------------------------------------------------------------------
	assign pend1 = flags1 & en1;
	assign pend2 = flags2 & en2;

	// Priority steering applies only with two levels on; otherwise the
	// single level needs both the global and the peripheral enable
	always_comb begin
		if (priority_levels_on) begin
			next_high = high_level_global_en
				&& (|(pend1 & prio1) || |(pend2 & prio2));       // [RQ20]
			next_low  = high_level_global_en && low_level_global_en
				&& (|(pend1 & ~prio1) || |(pend2 & ~prio2));     // [RQ14]
		end else begin
			next_high = high_level_global_en && low_level_global_en
				&& (|pend1 || |pend2);                           // [RQ10]
			next_low  = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			irq_high <= 1'b0;
			irq_low  <= 1'b0;
		end else begin
			irq_high <= next_high;                              // [RQ21]
			irq_low  <= next_low;                               // [RQ21]
		end
	end

	// ------------------------------------------------------------------
	// APB read and response: one wait-free access phase
	// ------------------------------------------------------------------
	always_comb begin
		mapped     = 1'b1;
		next_rdata = RDATA_ZERO;
		case (paddr)
			OFS_FLAGS2:  next_rdata[7:0] = flags2;
			OFS_EN1:     next_rdata[7:0] = en1;
			OFS_EN2:     next_rdata[7:0] = en2;
			OFS_PRIO1:   next_rdata[7:0] = prio1;
			OFS_PRIO2:   next_rdata[7:0] = prio2;
			OFS_RCAUSE:  next_rdata[7:0] = rcause;
			OFS_CORECTL: next_rdata[1:0] = corectl;
			OFS_FLAGS1:  next_rdata[7:0] = flags1;
			default:     mapped = 1'b0;
		endcase
	end

	// Response registered in setup so pready is high in the access phase
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RDATA_ZERO;
		end else if (psel && !penable) begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= pwrite ? RDATA_ZERO : next_rdata;
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= RDATA_ZERO;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	a_osc_flag_set : assert property (@(posedge sys_clk)
		disable iff (reset) osc_fail_evt |=> flags2[7]) // [RQ1]
		else $error("oscillator fail flag not set");
	a_unimpl_zero : assert property (@(posedge sys_clk)
		disable iff (reset)
		!flags2[BIT_UNIMPL] && !en2[BIT_UNIMPL] && !prio2[BIT_UNIMPL]) // [RQ3]
		else $error("bit 5 not zero");
	a_cc2_pwm_quiet : assert property (@(posedge sys_clk)
		disable iff (reset)
		(cc2_event && cc2_mode == 2'h3 && !flags2[0] && !wr_flags2)
		|=> !flags2[0]) // [RQ8]
		else $error("capture flag set in pwm mode");
	a_flag_clear : assert property (@(posedge sys_clk) disable iff (reset)
		(wr_flags2 && !pwdata[1] && !timer3_ovf_evt) |=> !flags2[1]) // [RQ7]
		else $error("timer 3 flag not cleared");
	a_single_level : assert property (@(posedge sys_clk)
		disable iff (reset)
		!priority_levels_on && !low_level_global_en |=> !irq_high) // [RQ10]
		else $error("request without peripheral enable");
	a_low_gated : assert property (@(posedge sys_clk) disable iff (reset)
		!high_level_global_en |=> !irq_low && !irq_high) // [RQ20]
		else $error("request while globally disabled");
	a_high_route : assert property (@(posedge sys_clk) disable iff (reset)
		(priority_levels_on && high_level_global_en
		&& |(flags2 & en2 & prio2)) |=> irq_high) // [RQ21]
		else $error("high request missing");
	a_enable_reset : assert property (@(posedge sys_clk)
		$fell(reset) |-> en1 == RST_ENABLE && en2 == RST_ENABLE
		&& prio2 == MASK_GROUP2) // [RQ15]
		else $error("enable or priority reset value wrong");
	a_apb_ready : assert property (@(posedge sys_clk) disable iff (reset)
		(psel && !penable) |=> pready)
		else $error("no ready in access phase");
	a_small_pkg_zero : assert property (@(posedge sys_clk) // [RQ13]
		disable iff (reset)
		!SMALL_PACKAGE || (!en1[BIT_PARPORT] && !prio1[BIT_PARPORT]
		&& !flags1[BIT_PARPORT]))
		else $error("parallel port bit not zero");
	a_flag1_set : assert property (@(posedge sys_clk) // [RQ19]
		disable iff (reset) flags1_evt[0] |=> flags1[0])
		else $error("first group flag lost an event");
	a_rdata_upper : assert property (@(posedge sys_clk)
		disable iff (reset) pready |-> prdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
endmodule

// File: verif/pifp_event_src.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Peripheral event sources: one-cycle pulses on command
// ----------------------------------------------------------------
module pifp_event_src (
	input  wire logic       sys_clk,         // System clock
	input  wire logic       reset,           // Synchronous reset, high
	input  wire logic       go,              // Fire one event
	input  wire logic [3:0] sel,             // 0..5 group two, 6..13 group one
	output logic            osc_fail_evt,    // Oscillator failed
	output logic            cmp_change_evt,  // Comparator changed
	output logic            nv_write_done,   // Memory write completed
	output logic            bus_coll_evt,    // Bus collision
	output logic            timer3_ovf_evt,  // Timer 3 overflow
	output logic            cc2_event,       // Capture or compare event
	output logic      [7:0] flags1_evt       // First-group events
);
	logic [13:0] pulse;

	// Registered so each pulse lasts as many clocks as go is held high, never a glitch
	always_ff @(posedge sys_clk) begin
		if (reset || !go) begin
			pulse <= 14'h0000;
		end else begin
			pulse <= 14'h0001 << sel;
		end
	end

	// Fan the pulse vector out to the source lines
	assign osc_fail_evt   = pulse[0];
	assign cmp_change_evt = pulse[1];
	assign nv_write_done  = pulse[2];
	assign bus_coll_evt   = pulse[3];
	assign timer3_ovf_evt = pulse[4];
	assign cc2_event      = pulse[5];
	assign flags1_evt     = pulse[13:6];
endmodule

// File: verif/peripheral_irq_flag_enable_priority_test.sv
`timescale 1ns/1ps
module peripheral_irq_flag_enable_priority_test import pifp_pkg::*;;
	// ------------------------------------------------------------
	// Stimulus signals and design
	// ------------------------------------------------------------
	logic        sys_clk = 1'b0;
	logic        reset = 1'b1;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic        pready, pslverr, rerr, irq_high, irq_low;
	logic        volt_above = 1'b0, volt_below = 1'b0, vdir = 1'b0;
	logic [1:0]  cc2_mode = 2'h1;
	logic [2:0]  rc_pulse = 3'h0;
	logic        go = 1'b0;
	logic [3:0]  sel = 4'h0;
	logic        osc, cmp, nvw, bcol, t3, cc2;
	logic [7:0]  f1;
	int          errors = 0, checks = 0;

	// 50 ns period
	always #25 sys_clk = ~sys_clk;

	pifp_event_src u_pifp_event_src (.sys_clk(sys_clk), .reset(reset),
		.go(go), .sel(sel), .osc_fail_evt(osc), .cmp_change_evt(cmp),
		.nv_write_done(nvw), .bus_coll_evt(bcol), .timer3_ovf_evt(t3),
		.cc2_event(cc2), .flags1_evt(f1));

	pifp_irq_unit u_pifp_irq_unit (.sys_clk(sys_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_fail_evt(osc), .cmp_change_evt(cmp),
		.nv_write_done(nvw), .bus_coll_evt(bcol), .volt_above(volt_above),
		.volt_below(volt_below), .voltage_direction_sel(vdir),
		.timer3_ovf_evt(t3), .cc2_event(cc2), .cc2_mode(cc2_mode),
		.flags1_evt(f1), .cfg_soft_bor(1'b1), .por_event(1'b1),
		.bor_event(1'b0), .rst_instr(rc_pulse[2]),
		.wdt_timeout(rc_pulse[1]), .sleep_entry(rc_pulse[0]),
		.irq_high(irq_high), .irq_low(irq_low));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// APB master: holds the request until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			errors++;
			$display("MISMATCH t=%0t no pready", $time);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h0, d});
	endtask

	task automatic rd_exp(input logic [7:0] a, input logic [7:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdat, {24'h0, exp});
	endtask

	task automatic fire(input logic [3:0] s);
		@(posedge sys_clk);
		go <= 1'b1;
		sel <= s;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic rc_hit(input logic [2:0] p);
		@(posedge sys_clk);
		rc_pulse <= p;
		@(posedge sys_clk);
		rc_pulse <= 3'h0;
		repeat (2) @(posedge sys_clk);
	endtask

	// Requests are registered, so let them settle before looking
	task automatic irq_exp(input logic h, input logic l);
		repeat (3) @(posedge sys_clk);
		chk({30'h0, irq_high, irq_low}, {30'h0, h, l});
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values();
		rd_exp(OFS_FLAGS2, 8'h00);
		rd_exp(OFS_EN1, 8'h00);
		rd_exp(OFS_EN2, 8'h00);
		rd_exp(OFS_PRIO1, 8'hFF);
		rd_exp(OFS_PRIO2, 8'hDF);
		rd_exp(OFS_RCAUSE, 8'h5D);
	endtask

	task automatic t_masks();
		wr(OFS_EN1, 8'hFF);
		rd_exp(OFS_EN1, 8'hFF);
		wr(OFS_EN2, 8'hFF);
		rd_exp(OFS_EN2, 8'hDF);
		wr(OFS_FLAGS2, 8'hFF);
		rd_exp(OFS_FLAGS2, 8'hDF);
		wr(OFS_FLAGS2, 8'h00);
		wr(OFS_PRIO2, 8'h00);
		rd_exp(OFS_PRIO2, 8'h00);
		apb(1'b1, 8'h20, 32'h0000_00AA);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b0, 8'h20, 32'h0);
		chk(rdat, 32'h0);
		wr(OFS_EN1, 8'h00);
		wr(OFS_EN2, 8'h00);
	endtask

	task automatic t_flags();
		int bits[6] = '{7, 6, 4, 3, 1, 0};
		for (int i = 0; i < 6; i++) begin
			fire(4'(i));
			rd_exp(OFS_FLAGS2, 8'h01 << bits[i]);
			wr(OFS_FLAGS2, 8'h00);
			rd_exp(OFS_FLAGS2, 8'h00);
		end
		cc2_mode <= 2'h2;
		fire(4'h5);
		rd_exp(OFS_FLAGS2, 8'h01);
		wr(OFS_FLAGS2, 8'h00);
		cc2_mode <= 2'h3;
		fire(4'h5);
		rd_exp(OFS_FLAGS2, 8'h00);
		volt_above <= 1'b1;
		fire(4'hF);
		rd_exp(OFS_FLAGS2, 8'h00);
		volt_below <= 1'b1;
		fire(4'hF);
		rd_exp(OFS_FLAGS2, 8'h04);
		wr(OFS_FLAGS2, 8'h00);
		vdir <= 1'b1;
		volt_above <= 1'b0;
		fire(4'hF);
		volt_above <= 1'b1;
		fire(4'hF);
		rd_exp(OFS_FLAGS2, 8'h04);
		wr(OFS_FLAGS2, 8'h00);
		fire(4'hC);
		rd_exp(OFS_FLAGS1, 8'h40);
		wr(OFS_FLAGS1, 8'h00);
	endtask

	task automatic t_irq();
		wr(OFS_EN2, 8'h02);
		fire(4'h4);
		irq_exp(1'b0, 1'b0);
		wr(OFS_CORECTL, 8'h02);
		irq_exp(1'b0, 1'b0);
		wr(OFS_CORECTL, 8'h03);
		irq_exp(1'b1, 1'b0);
		wr(OFS_RCAUSE, 8'hC1);
		irq_exp(1'b0, 1'b1);
		wr(OFS_CORECTL, 8'h02);
		irq_exp(1'b0, 1'b0);
		wr(OFS_PRIO2, 8'h02);
		irq_exp(1'b1, 1'b0);
		wr(OFS_FLAGS2, 8'h00);
		irq_exp(1'b0, 1'b0);
		wr(OFS_RCAUSE, 8'h41);
	endtask

	task automatic t_reset_cause();
		wr(OFS_RCAUSE, 8'hFF);
		rd_exp(OFS_RCAUSE, 8'hDF);
		wr(OFS_RCAUSE, 8'h00);
		rd_exp(OFS_RCAUSE, 8'h0C);
		rc_hit(3'h2);
		rd_exp(OFS_RCAUSE, 8'h04);
		rc_hit(3'h1);
		rd_exp(OFS_RCAUSE, 8'h00);
		wr(OFS_RCAUSE, 8'h10);
		rc_hit(3'h4);
		rd_exp(OFS_RCAUSE, 8'h00);
	endtask

	// ------------------------------------------------------------
	// Verdict, watchdog and main sequence
	// ------------------------------------------------------------
	task automatic results();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// The whole run needs well under 2000 cycles
	initial begin
		repeat (6000) @(posedge sys_clk);
		errors++;
		results();
	end

	initial begin
		repeat (5) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (2) @(posedge sys_clk);
		t_reset_values();
		t_masks();
		t_flags();
		t_irq();
		t_reset_cause();
		results();
	end
endmodule
